// [hw/nmf_pkg.sv]
// Package: constants and types for the navigation message framer
package nmf_pkg;

  localparam int CLK_HZ = 250_000_000;
  localparam int MS_PER_SEC = 1000;
  localparam int SLICE_MS = 100;
  localparam int SLICES_PER_SEC = 10;
  localparam int SLICE_CYC = CLK_HZ / MS_PER_SEC * SLICE_MS;

  localparam logic [7:0] FRM_START0 = 8'ha0;
  localparam logic [7:0] FRM_START1 = 8'ha2;
  localparam logic [7:0] FRM_END0 = 8'hb0;
  localparam logic [7:0] FRM_END1 = 8'hb3;
  localparam logic [15:0] CK_MASK = 16'h7fff;

  localparam logic [7:0] ID_DGPS = 8'h1d;
  localparam logic [7:0] ID_SVST = 8'h1e;
  localparam logic [15:0] LEN_DGPS = 16'h001a;
  localparam logic [15:0] LEN_SVST = 16'h0053;
  localparam int DGPS_WORDS = 7;
  localparam int SVST_WORDS = 21;
  localparam logic [6:0] DGPS_SRC_OFS = 7'h04;
  localparam logic [6:0] SVST_EPH_OFS = 7'h45;
  localparam logic [7:0] SRC_MAX = 8'h04;
  localparam logic [7:0] EPH_MAX = 8'h02;
  localparam logic [7:0] CODE_NONE = 8'h00;

  localparam int SYNC_INT_BIT = 0;
  localparam int SYNC_ST_LSB = 1;
  localparam logic [1:0] SYNC_NOT_ALIGNED = 2'h0;

  localparam logic [7:0] PE_LIMIT_DEG = 8'h3c;
  localparam logic [7:0] LP_LIMIT_DBHZ = 8'h1c;

  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_SYNC = 12'h008;
  localparam logic [11:0] REG_DR_IVAL = 12'h00c;
  localparam logic [11:0] REG_DR_CTRL = 12'h010;
  localparam logic [11:0] REG_DR_EFF = 12'h014;
  localparam logic [11:0] REG_DR_END = 12'h018;
  localparam logic [11:0] REG_DR_MEAN = 12'h01c;
  localparam logic [11:0] REG_TIME_TAG = 12'h020;
  localparam logic [11:0] REG_PR_TIME = 12'h024;
  localparam logic [11:0] REG_TIMES = 12'h028;
  localparam logic [11:0] REG_COUNTS = 12'h02c;
  localparam logic [11:0] REG_CN0_BASE = 12'h040;
  localparam logic [11:0] REG_DGPS_BASE = 12'h100;
  localparam logic [11:0] REG_SVST_BASE = 12'h180;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SEND_BIT = 1;
  localparam int DR_LOOP_BIT = 0;
  localparam int DR_PRESENT_BIT = 1;

  typedef enum logic [3:0] {
    F_IDLE, F_S0, F_S1, F_LH, F_LL, F_PAY, F_CK0, F_CK1, F_E0, F_E1
  } nmf_fstate_t;

endpackage : nmf_pkg

// [hw/nmf_stats.sv]
// Per-second signal statistics for one tracking channel
`timescale 1ns/1ns
module nmf_stats
  import nmf_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic slice_tick,
  input wire logic sec_tick,
  input wire logic meas_valid,
  input wire logic [7:0] meas_cn0,
  input wire logic [7:0] meas_phase_err,
  output logic [7:0] cn0_rep [SLICES_PER_SEC],
  output logic [7:0] pe_cnt,
  output logic [7:0] lp_cnt
);

  function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic hit);
    sat_inc = (hit && v != 8'hff) ? v + 8'h01 : v;
  endfunction : sat_inc

  logic [23:0] sum_reg;
  logic [15:0] n_reg;
  logic [7:0] hist_reg [SLICES_PER_SEC];
  logic [7:0] pe_run_reg;
  logic [7:0] lp_run_reg;
  logic [7:0] avg;
  logic pe_hit;
  logic lp_hit;

  // Empty slice reports zero rather than a stale value
  assign avg = (n_reg == 16'h0000) ? 8'h00 : 8'(sum_reg / {8'h00, n_reg}); // [RULE_03]
  assign pe_hit = meas_valid && (meas_phase_err > PE_LIMIT_DEG); // [RULE_07]
  assign lp_hit = meas_valid && (meas_cn0 < LP_LIMIT_DBHZ); // [RULE_08]

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sum_reg <= '0;
      n_reg <= '0;
    end else if (slice_tick) begin
      sum_reg <= meas_valid ? {16'h0000, meas_cn0} : 24'h000000;
      n_reg <= meas_valid ? 16'h0001 : 16'h0000;
    end else if (meas_valid && n_reg != 16'hffff) begin
      sum_reg <= sum_reg + {16'h0000, meas_cn0};
      n_reg <= n_reg + 16'h0001;
    end
  end

  // Oldest slice ends up in entry 0, so the report is in time order
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < SLICES_PER_SEC; i++) begin
        hist_reg[i] <= '0;
        cn0_rep[i] <= '0;
      end
    end else if (slice_tick) begin
      for (int i = 0; i < SLICES_PER_SEC - 1; i++) begin
        hist_reg[i] <= hist_reg[i + 1]; // [RULE_03]
      end
      hist_reg[SLICES_PER_SEC - 1] <= avg;
      if (sec_tick) begin
        for (int i = 0; i < SLICES_PER_SEC - 1; i++) begin
          cn0_rep[i] <= hist_reg[i + 1]; // [RULE_03]
        end
        cn0_rep[SLICES_PER_SEC - 1] <= avg;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pe_run_reg <= '0;
      lp_run_reg <= '0;
      pe_cnt <= '0;
      lp_cnt <= '0;
    end else if (sec_tick) begin
      pe_cnt <= pe_run_reg; // [RULE_07]
      lp_cnt <= lp_run_reg; // [RULE_08]
      pe_run_reg <= sat_inc(8'h00, pe_hit);
      lp_run_reg <= sat_inc(8'h00, lp_hit);
    end else begin
      pe_run_reg <= sat_inc(pe_run_reg, pe_hit);
      lp_run_reg <= sat_inc(lp_run_reg, lp_hit);
    end
  end

endmodule : nmf_stats

// [hw/nmf_framer.sv]
// Byte-stream framer: start, length, payload, checksum, end
`timescale 1ns/1ns
module nmf_framer
  import nmf_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [15:0] len,
  input wire logic [7:0] pay_byte,
  output logic [6:0] pay_idx,
  output logic busy,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready
);

  nmf_fstate_t state_reg;
  logic [15:0] len_reg;
  logic [15:0] cnt_reg;
  logic [15:0] ck_reg;
  logic [15:0] ck_out;
  logic adv;

  // Output byte only moves on once the host has taken it
  assign adv = !tx_valid || tx_ready;
  assign busy = (state_reg != F_IDLE) || tx_valid;
  assign pay_idx = cnt_reg[6:0];
  assign ck_out = ck_reg & CK_MASK;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= F_IDLE;
      len_reg <= '0;
      cnt_reg <= '0;
      ck_reg <= '0;
      tx_data <= '0;
      tx_valid <= 1'b0;
    end else if (adv) begin
      unique case (state_reg)
        F_IDLE: begin
          tx_valid <= 1'b0;
          if (start) begin
            len_reg <= len;
            state_reg <= F_S0;
          end
        end
        F_S0: begin
          tx_data <= FRM_START0; // [RULE_16]
          tx_valid <= 1'b1;
          state_reg <= F_S1;
        end
        F_S1: begin
          tx_data <= FRM_START1; // [RULE_16]
          state_reg <= F_LH;
        end
        F_LH: begin
          tx_data <= len_reg[15:8]; // [RULE_16] [RULE_18]
          state_reg <= F_LL;
        end
        F_LL: begin
          tx_data <= len_reg[7:0];
          cnt_reg <= '0;
          ck_reg <= '0;
          state_reg <= F_PAY;
        end
        F_PAY: begin
          tx_data <= pay_byte;
          ck_reg <= ck_reg + {8'h00, pay_byte};
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == len_reg - 16'h0001) begin
            state_reg <= F_CK0;
          end
        end
        F_CK0: begin
          tx_data <= ck_out[15:8]; // [RULE_17]
          state_reg <= F_CK1;
        end
        F_CK1: begin
          tx_data <= ck_out[7:0];
          state_reg <= F_E0;
        end
        F_E0: begin
          tx_data <= FRM_END0; // [RULE_17]
          state_reg <= F_E1;
        end
        F_E1: begin
          tx_data <= FRM_END1; // [RULE_17]
          state_reg <= F_IDLE;
        end
      endcase
    end
  end

endmodule : nmf_framer

// [hw/nmf_top.sv]
// Function
// (RULE_01) Sync flags bit 0: 0 for 2 ms coherent interval, 1 for 10 ms.
// (RULE_02) Sync state bits 2:1: none, code epoch, data bit, no millisecond errors.
// (RULE_03) Ten C/No entries, average dB-Hz per 100 ms slice, oldest first.
// (RULE_04) Delta range interval reads zero for loop frequency or no measurement.
// (RULE_05) Mean delta range time in ms, counted back from interval end.
// (RULE_06) Extrapolation time is ms from pseudo range time to the time tag.
// (RULE_07) Count phase errors above 60 degrees over the preceding second.
// (RULE_08) Count measurements below 28 dB-Hz over the preceding second.
// (RULE_09) Correction message carries identifier 29 in payload byte 0.
// (RULE_10) Both messages go out once per measurement cycle, one per second.
// (RULE_11) Correction payload is 26 bytes in the fixed field order.
// (RULE_12) Correction source codes 0 to 4; anything else is sent as 0.
// (RULE_13) Satellite state message carries identifier 30 in payload byte 0.
// (RULE_14) Satellite state payload is 83 bytes in the fixed field order.
// (RULE_15) Ephemeris flag codes 0 to 2; anything else is sent as 0.
// (RULE_16) Frame opens with two start bytes then two length bytes.
// (RULE_17) Frame closes with two checksum bytes then two end bytes.
// (RULE_18) Multi-byte fields go most significant byte first.
// (RULE_19) Host drops frames with bad delimiters or length and resyncs.
`timescale 1ns/1ns
module nmf_top
  import nmf_pkg::*;
#(
  parameter int SLICE_CYCLES = SLICE_CYC
)
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic MEAS_VALID,
  input wire logic [7:0] MEAS_CN0,
  input wire logic [7:0] MEAS_PHASE_ERR,
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY
);

  function automatic logic in_block(input logic [11:0] a, input logic [11:0] base, input int words);
    in_block = (a >= base) && (a < base + 12'(words * 4));
  endfunction : in_block

  function automatic logic [15:0] ms_diff(input logic [31:0] later, input logic [31:0] earlier);
    logic [31:0] d;
    d = later - earlier;
    ms_diff = d[15:0];
  endfunction : ms_diff

  // Register state
  logic ctrl_en_reg;
  logic send_req;
  logic [2:0] sync_reg;
  logic [31:0] dr_ival_reg;
  logic [1:0] dr_ctrl_reg;
  logic [31:0] dr_end_reg;
  logic [31:0] dr_mean_reg;
  logic [31:0] time_tag_reg;
  logic [31:0] pr_time_reg;
  logic [31:0] dgps_mem [DGPS_WORDS];
  logic [31:0] svst_mem [SVST_WORDS];
  logic [15:0] frames_reg;

  // Bus handshake
  logic setup_ph;
  logic wr_take;
  logic [31:0] rd_val;
  logic rd_err;

  // Timing
  logic [31:0] slice_cnt_reg;
  logic [3:0] slice_idx_reg;
  logic slice_tick_reg;
  logic sec_tick_reg;

  // Framing
  logic pend29_reg;
  logic pend30_reg;
  logic sel30_reg;
  logic fr_start;
  logic fr_busy;
  logic [6:0] pay_idx;
  logic [6:0] ofs;
  logic [7:0] pay_byte;
  logic [31:0] word;
  logic [7:0] raw_byte;

  // Measurement report fields
  logic [7:0] cn0_rep [SLICES_PER_SEC];
  logic [7:0] pe_cnt;
  logic [7:0] lp_cnt;
  logic [31:0] dr_eff;
  logic [15:0] mean_dr_ms;
  logic [15:0] extrap_ms;
  logic [7:0] sync_byte;

  assign setup_ph = PSEL && !PENABLE;
  assign wr_take = PSEL && PENABLE && PREADY && PWRITE;

  // Sync flags byte; software supplies the tracking loop state
  assign sync_byte = {5'h00, sync_reg[2:1], sync_reg[0]}; // [RULE_01] [RULE_02]

  assign dr_eff = (dr_ctrl_reg[DR_LOOP_BIT] || !dr_ctrl_reg[DR_PRESENT_BIT])
                  ? 32'h00000000 : dr_ival_reg; // [RULE_04]
  assign mean_dr_ms = ms_diff(dr_end_reg, dr_mean_reg); // [RULE_05]
  assign extrap_ms = ms_diff(time_tag_reg, pr_time_reg); // [RULE_06]

  // Answer is prepared in the setup cycle, so PREADY rises in the access cycle
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      PREADY <= 1'b0;
      PRDATA <= '0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= setup_ph;
      PRDATA <= (setup_ph && !PWRITE) ? rd_val : 32'h00000000;
      PSLVERR <= setup_ph && rd_err;
    end
  end

  always_comb begin
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    if (in_block(PADDR, REG_DGPS_BASE, DGPS_WORDS)) begin
      rd_val = dgps_mem[3'(PADDR[4:2])];
    end else if (in_block(PADDR, REG_SVST_BASE, SVST_WORDS)) begin
      // Block starts on a 128-byte boundary, so the low address bits are the word index
      rd_val = svst_mem[PADDR[6:2]];
    end else if (in_block(PADDR, REG_CN0_BASE, SLICES_PER_SEC)) begin
      rd_val = {24'h000000, cn0_rep[4'(PADDR[5:2] - REG_CN0_BASE[5:2])]}; // [RULE_03]
    end else begin
      unique case (PADDR)
        REG_CTRL: rd_val = {31'h00000000, ctrl_en_reg};
        REG_STATUS: rd_val = {frames_reg, 13'h0000, pend30_reg, pend29_reg, fr_busy};
        REG_SYNC: rd_val = {24'h000000, sync_byte};
        REG_DR_IVAL: rd_val = dr_ival_reg;
        REG_DR_CTRL: rd_val = {30'h00000000, dr_ctrl_reg};
        REG_DR_EFF: rd_val = dr_eff;
        REG_DR_END: rd_val = dr_end_reg;
        REG_DR_MEAN: rd_val = dr_mean_reg;
        REG_TIME_TAG: rd_val = time_tag_reg;
        REG_PR_TIME: rd_val = pr_time_reg;
        REG_TIMES: rd_val = {extrap_ms, mean_dr_ms};
        REG_COUNTS: rd_val = {16'h0000, lp_cnt, pe_cnt};
        default: rd_err = 1'b1;
      endcase
    end
  end

  // Control and measurement registers
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ctrl_en_reg <= 1'b0;
      sync_reg <= {SYNC_NOT_ALIGNED, 1'b0};
      dr_ival_reg <= '0;
      dr_ctrl_reg <= '0;
      dr_end_reg <= '0;
      dr_mean_reg <= '0;
      time_tag_reg <= '0;
      pr_time_reg <= '0;
    end else if (wr_take) begin
      unique case (PADDR)
        REG_CTRL: ctrl_en_reg <= PWDATA[CTRL_EN_BIT];
        REG_SYNC: sync_reg <= PWDATA[2:0]; // [RULE_01] [RULE_02]
        REG_DR_IVAL: dr_ival_reg <= PWDATA;
        REG_DR_CTRL: dr_ctrl_reg <= PWDATA[1:0];
        REG_DR_END: dr_end_reg <= PWDATA;
        REG_DR_MEAN: dr_mean_reg <= PWDATA;
        REG_TIME_TAG: time_tag_reg <= PWDATA;
        REG_PR_TIME: pr_time_reg <= PWDATA;
        default: ;
      endcase
    end
  end

  assign send_req = wr_take && (PADDR == REG_CTRL) && PWDATA[CTRL_SEND_BIT];

  // Payload words, most significant byte sent first
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < DGPS_WORDS; i++) begin
        dgps_mem[i] <= '0;
      end
      for (int i = 0; i < SVST_WORDS; i++) begin
        svst_mem[i] <= '0;
      end
    end else if (wr_take) begin
      if (in_block(PADDR, REG_DGPS_BASE, DGPS_WORDS)) begin
        dgps_mem[3'(PADDR[4:2])] <= PWDATA;
      end
      if (in_block(PADDR, REG_SVST_BASE, SVST_WORDS)) begin
        svst_mem[PADDR[6:2]] <= PWDATA;
      end
    end
  end

  // Slice and second strobes; a second is ten slices
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      slice_cnt_reg <= '0;
      slice_idx_reg <= '0;
      slice_tick_reg <= 1'b0;
      sec_tick_reg <= 1'b0;
    end else begin
      slice_tick_reg <= 1'b0;
      sec_tick_reg <= 1'b0;
      if (slice_cnt_reg == 32'(SLICE_CYCLES - 1)) begin
        slice_cnt_reg <= '0;
        slice_tick_reg <= 1'b1;
        if (slice_idx_reg == 4'(SLICES_PER_SEC - 1)) begin
          slice_idx_reg <= '0;
          sec_tick_reg <= 1'b1;
        end else begin
          slice_idx_reg <= slice_idx_reg + 4'h1;
        end
      end else begin
        slice_cnt_reg <= slice_cnt_reg + 32'h00000001;
      end
    end
  end

  nmf_stats u_stats (
    .clk(CLK_SYS),
    .nrst(NRST),
    .slice_tick(slice_tick_reg),
    .sec_tick(sec_tick_reg),
    .meas_valid(MEAS_VALID),
    .meas_cn0(MEAS_CN0),
    .meas_phase_err(MEAS_PHASE_ERR),
    .cn0_rep(cn0_rep),
    .pe_cnt(pe_cnt),
    .lp_cnt(lp_cnt)
  );

  // Pending flags: a new cycle's request wins over the launch that clears it
  assign fr_start = !fr_busy && (pend29_reg || pend30_reg);

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      pend29_reg <= 1'b0;
      pend30_reg <= 1'b0;
      sel30_reg <= 1'b0;
      frames_reg <= '0;
    end else begin
      if (fr_start) begin
        sel30_reg <= !pend29_reg;
        frames_reg <= frames_reg + 16'h0001;
        if (pend29_reg) begin
          pend29_reg <= 1'b0;
        end else begin
          pend30_reg <= 1'b0;
        end
      end
      if ((sec_tick_reg && ctrl_en_reg) || send_req) begin
        pend29_reg <= 1'b1; // [RULE_10]
        pend30_reg <= 1'b1; // [RULE_10]
      end
    end
  end

  // Payload byte for the framer; byte 0 is the message identifier
  assign ofs = pay_idx - 7'h01;

  always_comb begin
    word = sel30_reg ? svst_mem[5'(ofs[6:2])] : dgps_mem[3'(ofs[4:2])];
    raw_byte = word[8'(31 - 8 * int'(ofs[1:0])) -: 8]; // [RULE_18]
    pay_byte = raw_byte;
    if (pay_idx == 7'h00) begin
      pay_byte = sel30_reg ? ID_SVST : ID_DGPS; // [RULE_09] [RULE_13]
    end else if (!sel30_reg && ofs == DGPS_SRC_OFS && raw_byte > SRC_MAX) begin
      pay_byte = CODE_NONE; // [RULE_12]
    end else if (sel30_reg && ofs == SVST_EPH_OFS && raw_byte > EPH_MAX) begin
      pay_byte = CODE_NONE; // [RULE_15]
    end
  end

  nmf_framer u_framer (
    .clk(CLK_SYS),
    .nrst(NRST),
    .start(fr_start),
    .len(pend29_reg ? LEN_DGPS : LEN_SVST), // [RULE_11] [RULE_14]
    .pay_byte(pay_byte),
    .pay_idx(pay_idx),
    .busy(fr_busy),
    .tx_data(TX_DATA),
    .tx_valid(TX_VALID),
    .tx_ready(TX_READY)
  );

endmodule : nmf_top

// [verification/nmf_chk.sv]
// Checker: APB answer and frame layout on the top-level ports
`timescale 1ns/1ns
module nmf_chk
  import nmf_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  input wire logic TX_READY
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  logic [7:0] idx_reg;
  logic [7:0] len_reg;
  // Byte position in frame; valid drops between frames, so it restarts there
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) idx_reg <= 8'h00;
    else if (!TX_VALID) idx_reg <= 8'h00;
    else if (TX_READY) idx_reg <= idx_reg + 8'h01;
  end
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) len_reg <= 8'h00;
    else if (TX_VALID && TX_READY && idx_reg == 8'h03) len_reg <= TX_DATA;
  end
  apb_answer_a: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("apb answer not one cycle after setup");
  apb_error_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error response without ready or with data");
  tx_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("tx byte changed while stalled");
  start_first_a: assert property ($rose(TX_VALID) |-> TX_DATA == FRM_START0)
    else $error("frame does not open with first start byte");
  start_second_a: assert property (TX_VALID && idx_reg == 8'h01 |-> TX_DATA == FRM_START1)
    else $error("second start byte wrong");
  length_value_a: assert property (TX_VALID && idx_reg == 8'h03 |-> TX_DATA == LEN_DGPS[7:0] || TX_DATA == LEN_SVST[7:0])
    else $error("payload length wrong");
  msg_ident_a: assert property (TX_VALID && idx_reg == 8'h04 |-> TX_DATA == (len_reg == LEN_DGPS[7:0] ? ID_DGPS : ID_SVST))
    else $error("identifier does not match length");
  end_first_a: assert property (TX_VALID && idx_reg > 8'h04 && idx_reg == len_reg + 8'h06 |-> TX_DATA == FRM_END0)
    else $error("first end byte wrong");
  end_drop_a: assert property (TX_VALID && TX_READY && idx_reg > 8'h04 && idx_reg == len_reg + 8'h07 |-> TX_DATA == FRM_END1 ##1 !TX_VALID)
    else $error("frame does not close after end bytes");
endmodule : nmf_chk

bind nmf_top nmf_chk u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY));

// [verification/nmf_host.sv]
// Host model: takes frame bytes, optionally stalling
`timescale 1ns/1ns
module nmf_host
  import nmf_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic slow
);
  logic [7:0] byte_q [$];
  logic [1:0] n_reg;
  // Slow mode takes one byte in four to stress the hold path
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_ready <= 1'b0;
      n_reg <= 2'h0;
    end else begin
      n_reg <= n_reg + 2'h1;
      tx_ready <= !slow || n_reg == 2'h0;
      if (tx_valid && tx_ready) byte_q.push_back(tx_data);
    end
  end
endmodule : nmf_host

// [verification/nmf_top_bench.sv]
// Testbench: APB register checks, statistics and frame contents
`timescale 1ns/1ns
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin mismatches++; $display("Error %s expected %h seen %h", nm, e, s); end end
module nmf_top_bench;
  import nmf_pkg::*;
  localparam int SLC = 20;
  localparam int SEC = SLC * SLICES_PER_SEC;
  logic CLK_SYS = 0;
  logic NRST = 0;
  logic PSEL = 0;
  logic PENABLE = 0;
  logic PWRITE = 0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic MEAS_VALID = 0;
  logic [7:0] MEAS_CN0 = 8'h00;
  logic [7:0] MEAS_PHASE_ERR = 8'h00;
  logic [7:0] TX_DATA;
  logic TX_VALID;
  logic TX_READY;
  logic slow = 0;
  logic [31:0] rd;
  logic err;
  int cyc = 0;
  int mismatches = 0;
  int samples_checked = 0;
  always #2 CLK_SYS = ~CLK_SYS;
  nmf_top #(.SLICE_CYCLES(SLC)) dut (.CLK_SYS(CLK_SYS), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEAS_VALID(MEAS_VALID),
    .MEAS_CN0(MEAS_CN0), .MEAS_PHASE_ERR(MEAS_PHASE_ERR), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY));
  nmf_host host (.clk(CLK_SYS), .nrst(NRST), .tx_data(TX_DATA), .tx_valid(TX_VALID), .tx_ready(TX_READY), .slow(slow));
  // Samples sit mid-slice so a few cycles of phase offset cannot move them
  always @(posedge CLK_SYS) begin
    cyc <= NRST ? cyc + 1 : 0;
    MEAS_VALID <= NRST && (cyc % SLC >= 5) && (cyc % SLC < 15);
    MEAS_CN0 <= 8'(23 + (cyc / SLC) % 10);
    MEAS_PHASE_ERR <= ((cyc / SLC) % 10 < 3) ? 8'h3d : 8'h3c;
    if (cyc > 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  function automatic logic [7:0] pb(int k);
    return 8'(k * 7 + 3);
  endfunction : pb
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1;
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask : apb
  task chk_rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask : chk_rd
  task nxt(input string nm, input logic [7:0] e);
    logic [7:0] b;
    b = host.byte_q.pop_front();
    `CHK(nm, e, b)
  endtask : nxt
  task chk_frame(input logic [7:0] id, input logic [15:0] len, input int fpos, input logic [7:0] fval);
    logic [15:0] sum;
    logic [7:0] e;
    sum = 16'(id);
    nxt("start0", FRM_START0);
    nxt("start1", FRM_START1);
    nxt("len_hi", len[15:8]);
    nxt("len_lo", len[7:0]);
    nxt("msg_id", id);
    for (int k = 1; k < int'(len); k++) begin
      e = (k == fpos) ? fval : pb(k);
      sum = sum + 16'(e);
      nxt("payload", e);
    end
    sum = sum & CK_MASK;
    nxt("ck_hi", sum[15:8]);
    nxt("ck_lo", sum[7:0]);
    nxt("end0", FRM_END0);
    nxt("end1", FRM_END1);
  endtask : chk_frame
  task end_of_test;
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (2) @(posedge CLK_SYS);
    NRST <= 1;
    chk_rd("ctrl", REG_CTRL, 32'h0);
    chk_rd("status", REG_STATUS, 32'h0);
    for (int i = 0; i < 8; i++) begin
      apb(1, REG_SYNC, 32'(i));
      chk_rd("sync", REG_SYNC, 32'(i));
    end
    apb(1, REG_DR_IVAL, 32'h03e801f4);
    for (int i = 0; i < 4; i++) begin
      apb(1, REG_DR_CTRL, 32'(i));
      chk_rd("dr_eff", REG_DR_EFF, i == 2 ? 32'h03e801f4 : 32'h0);
    end
    apb(1, REG_DR_END, 32'h3e8);
    apb(1, REG_DR_MEAN, 32'h1f4);
    apb(1, REG_TIME_TAG, 32'h660d0);
    apb(1, REG_PR_TIME, 32'h660c3);
    chk_rd("times", REG_TIMES, 32'h000d01f4);
    apb(0, 12'h030, 32'h0);
    `CHK("unmapped", 2'b10, {err, |rd})
    wait (cyc > 2 * SEC && cyc % SEC == 100);
    for (int i = 0; i < 10; i++) chk_rd("cn0", REG_CN0_BASE + 12'(4 * i), 32'(23 + i));
    chk_rd("counts", REG_COUNTS, 32'h321e);
    for (int w = 0; w < SVST_WORDS; w++) apb(1, REG_SVST_BASE + 12'(4 * w), {pb(4*w+1), pb(4*w+2), pb(4*w+3), pb(4*w+4)});
    for (int w = 0; w < DGPS_WORDS; w++) apb(1, REG_DGPS_BASE + 12'(4 * w), {pb(4*w+1), pb(4*w+2), pb(4*w+3), pb(4*w+4)});
    // Codes past the legal range must go out as zero
    for (int k = 0; k < 6; k++) begin
      apb(1, REG_DGPS_BASE + 12'h004, {8'(k), pb(6), pb(7), pb(8)});
      apb(1, REG_SVST_BASE + 12'h044, {pb(69), 8'(k), pb(71), pb(72)});
      slow = k[0];
      host.byte_q.delete();
      apb(1, REG_CTRL, 32'h2);
      while (host.byte_q.size() < 125) @(posedge CLK_SYS);
      chk_frame(ID_DGPS, LEN_DGPS, 5, k <= 4 ? 8'(k) : CODE_NONE);
      chk_frame(ID_SVST, LEN_SVST, 70, k <= 2 ? 8'(k) : CODE_NONE);
    end
    slow = 0;
    apb(1, REG_CTRL, 32'h1);
    wait (cyc % SEC == 150);
    host.byte_q.delete();
    repeat (2 * SEC) @(posedge CLK_SYS);
    `CHK("per_second", 250, host.byte_q.size())
    end_of_test();
  end
endmodule : nmf_top_bench
